// File: i2c_slave_interface.sv
// two-wire bus slave: start/stop detect, address compare, byte shift, clock hold
// assumes scl/sda come from pins (synchronised here); software side is on clk
`timescale 1ns/1ps
`include "i2c_slave_params.svh"
module i2c_slave_interface
  import i2c_slave_pkg::*;
#(
  parameter int TO_UNIT_CYCLES = `I2C_TO_UNIT_NS / `I2C_CLK_PERIOD_NS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire i2c_cfg_t    cfg,
  input  wire logic        data_wr,
  input  wire logic [7:0]  data_wr_byte,
  input  wire logic        data_rd,
  input  wire logic        timeout_flag_clr,
  output i2c_status_t      status,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic      [7:0]  serial_data_reg,
  output logic             irq,
  output logic             wake_req
);
  localparam i2c_status_t STATUS_POR = '{transfer_done_flag: `I2C_DONE_POR, addr_matched_flag: 1'b0,
                                         bus_busy_flag: 1'b0, rw_dir_flag: 1'b0,
                                         rx_ack_flag: `I2C_RXACK_POR, timeout_flag: 1'b0};

  // pin synchronisers: first stage read only by second
  logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det, enabled;
  assign scl_rise  = scl_s_q & ~scl_p_q;
  assign scl_fall  = ~scl_s_q & scl_p_q;
  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign enabled   = cfg.serial_unit_en & ~cfg.uart_select & (cfg.serial_mode_field == `I2C_MODE_SLAVE);

  function automatic logic [`I2C_TO_CNT_W-1:0] to_limit(input logic [5:0] sel);
    to_limit = `I2C_TO_CNT_W'((32'(sel) + 32'd1) * 32'(TO_UNIT_CYCLES));
  endfunction

  i2c_state_t                state_q, state_d;
  logic [3:0]                bitcnt_q, bitcnt_d;
  logic [7:0]                rxsh_q, rxsh_d, txsh_q, txsh_d;
  logic                      ack_tx_q, ack_tx_d;
  logic                      ack_data_q, ack_data_d;
  logic                      sda_oe_q, sda_oe_d;
  logic                      irq_q, irq_d, wake_q, wake_d;
  logic                      to_act_q, to_act_d;
  logic                      late_hold_q, late_hold_d;
  logic [`I2C_TO_CNT_W-1:0]  to_cnt_q, to_cnt_d;
  i2c_status_t               st_q, st_d;
  logic                      buf_in_valid, buf_in_ready;

  assign buf_in_valid = (state_q == ST_PUSH) |
                        ((state_q == ST_RX) & scl_fall & (bitcnt_q == `I2C_BYTE_BITS));

  always_comb begin
    state_d    = state_q;
    bitcnt_d   = bitcnt_q;
    rxsh_d     = rxsh_q;
    txsh_d     = txsh_q;
    ack_tx_d   = ack_tx_q;
    ack_data_d = ack_data_q;
    sda_oe_d   = sda_oe_q;
    irq_d      = 1'b0;
    wake_d     = 1'b0;
    late_hold_d = 1'b0;
    to_act_d   = to_act_q;
    to_cnt_d   = to_cnt_q;
    st_d       = st_q;
    if (timeout_flag_clr) st_d.timeout_flag = 1'b0;

    case (state_q)
      ST_ADDR: begin
        if (scl_rise) begin
          rxsh_d   = {rxsh_q[6:0], sda_s_q};
          bitcnt_d = bitcnt_q + 4'h1;
        end else if (scl_fall && bitcnt_q == `I2C_BYTE_BITS) begin
          if (rxsh_q[7:1] == cfg.own_address_reg[7:`I2C_ADDR_LSB]) begin
            st_d.addr_matched_flag = 1'b1;
            st_d.rw_dir_flag       = rxsh_q[0];
            irq_d                  = cfg.serial_irq_en;
            wake_d                 = cfg.wake_on_match_en;
            sda_oe_d   = 1'b1;
            ack_tx_d   = 1'b0;
            ack_data_d = 1'b0;
            to_act_d   = 1'b1;
            state_d    = ST_ACK;
          end else begin
            state_d = ST_IGNORE;
          end
        end
      end
      ST_ACK: begin
        // sample master ack after transmitted byte
        if (scl_rise && ack_tx_q) st_d.rx_ack_flag = sda_s_q;
        if (scl_fall) begin
          sda_oe_d = 1'b0;
          bitcnt_d = 4'h0;
          st_d.transfer_done_flag = 1'b1;
          irq_d = cfg.serial_irq_en & ack_data_q;
          // release on no ack and wait for stop
          if (ack_tx_q && st_q.rx_ack_flag) state_d = ST_IGNORE;
          else state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cfg.tx_rx_select && data_wr) begin
          txsh_d   = data_wr_byte;
          sda_oe_d = ~data_wr_byte[7];
          st_d.transfer_done_flag = 1'b0;
          state_d  = ST_TX;
        end else if (!cfg.tx_rx_select && data_rd) begin
          st_d.transfer_done_flag = 1'b0;
          state_d  = ST_RX;
        end
      end
      ST_RX: begin
        if (scl_rise) begin
          rxsh_d   = {rxsh_q[6:0], sda_s_q};
          bitcnt_d = bitcnt_q + 4'h1;
        end else if (scl_fall && bitcnt_q == `I2C_BYTE_BITS) begin
          // byte enters buffer at once; stall only when it is full
          if (buf_in_ready) begin
            // ack level set up in the low phase
            sda_oe_d   = ~cfg.tx_ack_ctrl;
            ack_tx_d   = 1'b0;
            ack_data_d = 1'b1;
            state_d    = ST_ACK;
          end else begin
            state_d = ST_PUSH;
          end
        end
      end
      ST_PUSH: begin
        // received byte waits in rxsh until buffer has room; clock held while buffer is full
        if (buf_in_ready) begin
          // keep scl low one more cycle so the ack level settles first
          late_hold_d = 1'b1;
          sda_oe_d   = ~cfg.tx_ack_ctrl;
          ack_tx_d   = 1'b0;
          ack_data_d = 1'b1;
          state_d    = ST_ACK;
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (bitcnt_q == `I2C_BYTE_BITS - 4'h1) begin
            sda_oe_d   = 1'b0;
            ack_tx_d   = 1'b1;
            ack_data_d = 1'b1;
            state_d    = ST_ACK;
          end else begin
            txsh_d   = {txsh_q[6:0], 1'b0};
            sda_oe_d = ~txsh_q[6];
            bitcnt_d = bitcnt_q + 4'h1;
          end
        end
      end
      ST_IDLE, ST_IGNORE: ;
      default: state_d = ST_IDLE;
    endcase

    // time-out: run after match, restart on each scl fall
    if (to_act_q) begin
      to_cnt_d = scl_fall ? '0 : to_cnt_q + 1'b1;
      if (cfg.timeout_en && to_cnt_q >= to_limit(cfg.timeout_sel)) begin
        st_d              = STATUS_POR;
        st_d.timeout_flag = 1'b1;
        irq_d             = cfg.serial_irq_en;
        to_act_d          = 1'b0;
        sda_oe_d          = 1'b0;
        state_d           = ST_IDLE;
      end
    end

    if (start_det) begin
      st_d.bus_busy_flag      = 1'b1;
      st_d.addr_matched_flag  = 1'b0;
      st_d.transfer_done_flag = 1'b0;
      sda_oe_d = 1'b0;
      bitcnt_d = 4'h0;
      state_d  = ST_ADDR;
    end else if (stop_det) begin
      st_d.bus_busy_flag     = 1'b0;
      st_d.addr_matched_flag = 1'b0;
      sda_oe_d = 1'b0;
      to_act_d = 1'b0;
      state_d  = ST_IDLE;
    end
    if (!to_act_d) to_cnt_d = '0;

    if (!enabled) begin
      st_d              = STATUS_POR;
      st_d.timeout_flag = st_q.timeout_flag & ~timeout_flag_clr;
      state_d  = ST_IDLE;
      sda_oe_d = 1'b0;
      to_act_d = 1'b0;
      irq_d    = 1'b0;
      wake_d   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= ST_IDLE;
      bitcnt_q   <= 4'h0;
      rxsh_q     <= 8'h00;
      txsh_q     <= 8'h00;
      ack_tx_q   <= 1'b0;
      ack_data_q <= 1'b0;
      sda_oe_q   <= 1'b0;
      irq_q      <= 1'b0;
      wake_q     <= 1'b0;
      to_act_q   <= 1'b0;
      late_hold_q <= 1'b0;
      to_cnt_q   <= '0;
      st_q       <= STATUS_POR;
    end else begin
      state_q    <= state_d;
      bitcnt_q   <= bitcnt_d;
      rxsh_q     <= rxsh_d;
      txsh_q     <= txsh_d;
      ack_tx_q   <= ack_tx_d;
      ack_data_q <= ack_data_d;
      sda_oe_q   <= sda_oe_d;
      irq_q      <= irq_d;
      wake_q     <= wake_d;
      to_act_q   <= to_act_d;
      late_hold_q <= late_hold_d;
      to_cnt_q   <= to_cnt_d;
      st_q       <= st_d;
    end
  end

  i2c_two_entry_buf #(
    .WIDTH (8),
    .DEPTH (`I2C_BUF_DEPTH)
  ) u_rx_buf (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (rxsh_q),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (serial_data_reg)
  );

  assign sda_o    = 1'b0;
  assign sda_oe   = sda_oe_q;
  assign scl_o    = 1'b0;
  // stretch while waiting for software or buffer room
  assign scl_oe   = (state_q == ST_HOLD) | (state_q == ST_PUSH) | late_hold_q;
  assign status   = st_q;
  assign irq      = irq_q;
  assign wake_req = wake_q;
endmodule // i2c_slave_interface

// File: i2c_slave_params.svh
// constants for the two-wire slave: modes, counts, reset values, timing
// assumes the includer runs on a 20 MHz system clock
//
// Notes on behaviour
// - wake request on address match when enabled
// - received-ack flag 0 on master ack
// - keep sending while acked, else release
// - first seven bits MSB first are address
// - match sets matched flag and interrupt
// - eighth bit captured as read/write flag
// - drive low ack on ninth clock
// - start is sda fall, scl high; busy
// - interrupt on match, byte done, time-out
// - hold clock until software write or read
// - bytes eight bits, MSB first, after ack
// - receiver drives ack-control bit on ninth
// - received byte stored, written byte shifted
// - done flag clear moving, set finished
// - stop clears bus busy flag
// - address bits 7 to 1 compared only
`ifndef I2C_SLAVE_PARAMS_SVH
`define I2C_SLAVE_PARAMS_SVH

`define I2C_MODE_SLAVE    3'h6
`define I2C_BYTE_BITS     4'h8
`define I2C_ADDR_LSB      1
`define I2C_DONE_POR      1'h1
`define I2C_RXACK_POR     1'h1
`define I2C_CLK_PERIOD_NS 50
`define I2C_TO_UNIT_NS    1000000
`define I2C_TO_CNT_W      22
`define I2C_BUF_DEPTH     2

`endif

// File: i2c_slave_pkg.sv
// types shared by the two-wire slave and its software side
// assumes the params header defines no types
package i2c_slave_pkg;

  typedef struct packed {
    logic       uart_select;
    logic [2:0] serial_mode_field;
    logic       serial_unit_en;
    logic [7:0] own_address_reg;
    logic       tx_rx_select;
    logic       tx_ack_ctrl;
    logic       wake_on_match_en;
    logic       serial_irq_en;
    logic       timeout_en;
    logic [5:0] timeout_sel;
  } i2c_cfg_t;

  typedef struct packed {
    logic transfer_done_flag;
    logic addr_matched_flag;
    logic bus_busy_flag;
    logic rw_dir_flag;
    logic rx_ack_flag;
    logic timeout_flag;
  } i2c_status_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_HOLD, ST_RX, ST_PUSH, ST_TX, ST_IGNORE
  } i2c_state_t;

endpackage

// File: i2c_two_entry_buf.sv
// small fifo with valid/ready on both sides for received bytes
// assumes a single clock domain and asynchronous active-low reset
`timescale 1ns/1ps
module i2c_two_entry_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wp_d  = push ? inc(wp_q) : wp_q;
    rp_d  = pop ? inc(rp_q) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      if (push) mem_q[wp_q] <= in_data;
    end
  end
endmodule // i2c_two_entry_buf

// File: i2c_slave_interface_properties.sv
// checker for the two-wire slave, watching only the top module's ports
// assumes clk/reset_n of the slave; bound at the foot of this file
`timescale 1ns/1ps
module i2c_slave_interface_properties
  import i2c_slave_pkg::*;
#(
  parameter int TO_UNIT_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire i2c_cfg_t    cfg,
  input wire logic        data_wr,
  input wire logic [7:0]  data_wr_byte,
  input wire logic        data_rd,
  input wire logic        timeout_flag_clr,
  input wire i2c_status_t status,
  input wire logic        rx_valid,
  input wire logic        rx_ready,
  input wire logic [7:0]  serial_data_reg,
  input wire logic        irq,
  input wire logic        wake_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_start_busy;
    $fell(sda_i) && scl_i && $past(scl_i) && cfg.serial_unit_en |-> ##[1:6] status.bus_busy_flag;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not set after start");
  property p_stop_free;
    $rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:6] !status.bus_busy_flag;
  endproperty
  a_stop_free: assert property (p_stop_free) else $error("busy not cleared after stop");
  property p_no_start;
    $rose(sda_oe) |-> !scl_i;
  endproperty
  a_no_start: assert property (p_no_start) else $error("data pulled while clock high");
  property p_data_moves;
    $changed(sda_oe) |-> !scl_i || $past(!scl_i);
  endproperty
  a_data_moves: assert property (p_data_moves) else $error("data changed in clock high");
  property p_match_irq;
    $rose(status.addr_matched_flag) && cfg.serial_irq_en |-> ##[0:1] irq;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("no interrupt on match");
  property p_match_ack;
    $rose(status.addr_matched_flag) |-> ##[0:1] sda_oe;
  endproperty
  a_match_ack: assert property (p_match_ack) else $error("no ack on match");
  property p_wake;
    $rose(status.addr_matched_flag) && cfg.wake_on_match_en |-> ##[0:1] wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on match");
  property p_wake_off;
    !cfg.wake_on_match_en && !$past(cfg.wake_on_match_en) |-> !wake_req;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake while disabled");
  property p_rx_ack;
    $rose(rx_valid) && !cfg.tx_rx_select |-> sda_oe == !cfg.tx_ack_ctrl;
  endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("receive ack level wrong");
  property p_hold;
    $rose(status.addr_matched_flag) |-> ##[1:30] scl_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("clock not held after match");
  property p_hold_stay;
    scl_oe && status.transfer_done_flag && !data_rd && !data_wr && !rx_ready && !cfg.timeout_en &&
      cfg.serial_unit_en |=> scl_oe;
  endproperty
  a_hold_stay: assert property (p_hold_stay) else $error("clock hold dropped");
  c_rx: cover property ($rose(rx_valid));
  c_wake: cover property ($rose(wake_req));
  c_stop: cover property ($fell(status.bus_busy_flag));
endmodule // i2c_slave_interface_properties
bind i2c_slave_interface i2c_slave_interface_properties #(.TO_UNIT_CYCLES(TO_UNIT_CYCLES)) props_inst (
  .clk(clk), .reset_n(reset_n), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .cfg(cfg), .data_wr(data_wr), .data_wr_byte(data_wr_byte),
  .data_rd(data_rd), .timeout_flag_clr(timeout_flag_clr), .status(status), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .serial_data_reg(serial_data_reg), .irq(irq), .wake_req(wake_req));

// File: i2c_master_model.sv
// behavioural bus master: start, stop and byte transfers on open-drain lines
// assumes pulled-up wires resolved by the bench; 400 ns bus clock
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic     m_scl_oe,
  output logic     m_sda_oe,
  output logic     stuck
);
  initial begin
    m_scl_oe = 1'b0;
    m_sda_oe = 1'b0;
    stuck = 1'b0;
  end
  task automatic bit_x(input logic b, output logic s);
    int n;
    m_sda_oe = !b;
    repeat (HALF) @(negedge clk);
    m_scl_oe = 1'b0;
    for (n = 0; n < 4000 && !scl; n++) @(negedge clk);
    if (!scl) stuck = 1'b1;
    repeat (HALF) @(negedge clk);
    s = sda;
    m_scl_oe = 1'b1;
  endtask
  task automatic start();
    m_sda_oe = 1'b1;
    repeat (HALF) @(negedge clk);
    m_scl_oe = 1'b1;
  endtask
  task automatic stop();
    int n;
    m_sda_oe = 1'b1;
    repeat (HALF) @(negedge clk);
    m_scl_oe = 1'b0;
    for (n = 0; n < 4000 && !scl; n++) @(negedge clk);
    if (!scl) stuck = 1'b1;
    repeat (HALF) @(negedge clk);
    // sda rises while scl is high: the stop condition
    m_sda_oe = 1'b0;
    repeat (HALF) @(negedge clk);
  endtask
  // msb first, ninth bit is ack
  task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx, output logic ak);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(!ack, ak);
  endtask
endmodule // i2c_master_model

// File: tb_top.sv
// self-checking bench for the two-wire slave with a behavioural master
// assumes 20 MHz clk, pulled-up bus wires
`timescale 1ns/1ps
module tb_top;
  import i2c_slave_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        scl_oe, sda_oe, scl_o, sda_o, m_scl_oe, m_sda_oe, stuck, rx_valid, irq, wake_req;
  logic        data_wr = 1'b0, data_rd = 1'b0, rx_ready = 1'b0, ak;
  logic        timeout_flag_clr = 1'b0;
  logic [7:0]  data_wr_byte = 8'h00, serial_data_reg, rx;
  i2c_cfg_t    cfg = '{1'b0, 3'h6, 1'b1, 8'h5b, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 6'h00};
  i2c_status_t status;
  int          err_count = 0, tests_run = 0;
  wire         scl = !(m_scl_oe || scl_oe);
  wire         sda = !(m_sda_oe || sda_oe);
  always #25 clk = !clk;
  i2c_slave_interface #(.TO_UNIT_CYCLES(20)) i2c_slave_interface_inst (
    .clk(clk), .reset_n(reset_n), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .cfg(cfg), .data_wr(data_wr), .data_wr_byte(data_wr_byte),
    .data_rd(data_rd), .timeout_flag_clr(timeout_flag_clr), .status(status), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .serial_data_reg(serial_data_reg), .irq(irq), .wake_req(wake_req));
  i2c_master_model i2c_master_model_inst (
    .clk(clk), .scl(scl), .sda(sda), .m_scl_oe(m_scl_oe), .m_sda_oe(m_sda_oe), .stuck(stuck));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // software service of a held clock
  task automatic svc(input logic wr, input logic [7:0] b);
    repeat (8) @(negedge clk);
    chk(scl_oe, 1'b1);
    chk(status.transfer_done_flag, 1'b1);
    data_wr = wr;
    data_rd = !wr;
    data_wr_byte = b;
    @(negedge clk);
    data_wr = 1'b0;
    data_rd = 1'b0;
  endtask
  task automatic pop(input logic [7:0] exp);
    chk(rx_valid, 1'b1);
    chk(serial_data_reg, exp);
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
    @(negedge clk);
  endtask
  task automatic write_scn();
    i2c_master_model_inst.start();
    repeat (8) @(negedge clk);
    chk(status.bus_busy_flag, 1'b1);
    i2c_master_model_inst.xfer(8'h5a, 1'b0, rx, ak);
    chk(ak, 1'b0);
    chk({status.addr_matched_flag, status.rw_dir_flag}, 8'h02);
    svc(1'b0, 8'h00);
    i2c_master_model_inst.xfer(8'ha5, 1'b0, rx, ak);
    chk(ak, 1'b0);
    cfg.tx_ack_ctrl = 1'b1;
    svc(1'b0, 8'h00);
    i2c_master_model_inst.xfer(8'h3c, 1'b0, rx, ak);
    chk(ak, 1'b1);
    cfg.tx_ack_ctrl = 1'b0;
    pop(8'ha5);
    pop(8'h3c);
    chk(rx_valid, 1'b0);
    svc(1'b0, 8'h00);
    i2c_master_model_inst.stop();
    repeat (8) @(negedge clk);
    chk(status.bus_busy_flag, 1'b0);
  endtask
  task automatic miss_scn();
    i2c_master_model_inst.start();
    i2c_master_model_inst.xfer(8'h5c, 1'b0, rx, ak);
    chk(ak, 1'b1);
    chk(status.addr_matched_flag, 1'b0);
    i2c_master_model_inst.stop();
  endtask
  task automatic read_scn();
    cfg.wake_on_match_en = 1'b0;
    i2c_master_model_inst.start();
    i2c_master_model_inst.xfer(8'h5b, 1'b0, rx, ak);
    chk(ak, 1'b0);
    chk(status.rw_dir_flag, 1'b1);
    cfg.tx_rx_select = 1'b1;
    svc(1'b1, 8'hc3);
    i2c_master_model_inst.xfer(8'hff, 1'b1, rx, ak);
    chk(rx, 8'hc3);
    chk(status.rx_ack_flag, 1'b0);
    svc(1'b1, 8'h81);
    i2c_master_model_inst.xfer(8'hff, 1'b0, rx, ak);
    chk(rx, 8'h81);
    chk(status.rx_ack_flag, 1'b1);
    repeat (8) @(negedge clk);
    chk(sda_oe, 1'b0);
    i2c_master_model_inst.stop();
    cfg.tx_rx_select = 1'b0;
  endtask
  task automatic tmo_scn();
    cfg.timeout_en = 1'b1;
    i2c_master_model_inst.start();
    i2c_master_model_inst.xfer(8'h5a, 1'b0, rx, ak);
    repeat (40) @(negedge clk);
    chk(status.timeout_flag, 1'b1);
    chk({status.addr_matched_flag, status.bus_busy_flag, scl_oe}, 8'h00);
    timeout_flag_clr = 1'b1;
    @(negedge clk);
    timeout_flag_clr = 1'b0;
    chk(status.timeout_flag, 1'b0);
    cfg.timeout_en = 1'b0;
    i2c_master_model_inst.stop();
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    // slave mode set up at time zero
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    write_scn();
    miss_scn();
    read_scn();
    tmo_scn();
    chk(stuck, 1'b0);
    if (stuck) err_count++;
    wrap_up();
  end
endmodule // tb_top
